/* rtl/eth_flow_ctl.v */
// Ethernet flow control and receive buffer bookkeeping with AXI4-Lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "flow_ctl_regs.vh"

// Contract
// (R1) Auto bit lets watermarks drive flow control
// (R2) Start at full watermark, stop at empty
// (R3) Flow state drives TX and RX alike
// (R4) Manual set sends PAUSE with timer value
// (R5) Repeat PAUSE every 128*timer/2 TX clocks
// (R6) TX clock 2.5 MHz or 25 MHz
// (R7) Manual clear sends PAUSE with zero time
// (R8) Decrement bit reads zero, lowers counter
// (R9) Increment with decrement keeps counter unchanged
// (R10) Software disables controller before RX changes
// (R11) Buffer size field in 16-byte units
// (R12) Software changes size only with receive off
// (R13) PAUSE uses standard MAC control format
module eth_flow_ctl (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        speed_100,
	input  wire        rx_buffer_inc,
	input  wire [47:0] station_addr,
	output reg         controller_on,
	output reg         receive_enable,
	output reg  [6:0]  rx_buffer_size,
	output reg  [10:0] rx_buffer_bytes,
	output reg         tx_flow_ctl,
	output reg         rx_flow_ctl,
	output wire [7:0]  pause_tx_data,
	output wire        pause_tx_valid,
	output wire        pause_tx_last,
	input  wire        pause_tx_ready
);

	// Register state
	reg        auto_flow_ctl_en;
	reg        manual_flow_ctl_en;
	reg [15:0] pause_timer_value;
	reg [7:0]  wm_full;
	reg [7:0]  wm_empty;
	reg [7:0]  rx_buffer_counter;

	// Bus state
	reg        aw_full_q;
	reg        w_full_q;
	reg [7:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;

	// Flow state
	reg        auto_active_q;
	reg        fc_prev_q;
	reg        pend_on_q;
	reg        pend_zero_q;
	reg [5:0]  div_q;
	reg        tick_q;
	reg [21:0] rep_cnt_q;

	wire       gen_busy;
	wire       do_write;
	wire       buf_dec;
	wire       fc_on;
	wire       fc_rise;
	wire       fc_fall;
	wire       launch;
	wire       rep_due;
	wire [5:0] div_last;
	wire [21:0] rep_interval;
	wire [31:0] one_wr;
	wire [31:0] two_wr;
	wire [31:0] timer_wr;
	wire [31:0] wm_wr;

	// Divider end counts cut to the counter width
	localparam integer DIV_LAST_100 = `TX_DIV_100M - 1;
	localparam integer DIV_LAST_10  = `TX_DIV_10M - 1;
	localparam [15:0]  RST_ONE      = `RST_CONTROL_ONE;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
			end
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_CONTROL_ONE) || (a == `OFS_CONTROL_TWO) ||
				(a == `OFS_PAUSE_TIMER) || (a == `OFS_WATERMARK) ||
				(a == `OFS_STATUS);
		end
	endfunction

	// Write data merged under the byte strobes
	assign one_wr   = merge({16'h0000, controller_on, 6'h00, receive_enable,
		auto_flow_ctl_en, 2'b00, manual_flow_ctl_en, 4'h0}, w_data_q, w_strb_q);
	assign two_wr   = merge({21'h00_0000, rx_buffer_size, 4'h0}, w_data_q, w_strb_q);
	assign timer_wr = merge({16'h0000, pause_timer_value}, w_data_q, w_strb_q);
	assign wm_wr    = merge({16'h0000, wm_full, wm_empty}, w_data_q, w_strb_q);

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
	assign do_write      = aw_full_q && w_full_q && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// (R8) Write-one strobe, never stored
	assign buf_dec = do_write && (aw_addr_q == `OFS_CONTROL_ONE) &&
		w_strb_q[0] && w_data_q[`BIT_BUF_DEC];

	// Register writes; R12 and R10 are left to software, no lockout here
	always @(posedge aclk) begin
		if (!aresetn) begin
			controller_on      <= RST_ONE[`BIT_CTL_ON];
			receive_enable     <= 1'b0;
			auto_flow_ctl_en   <= 1'b0;
			manual_flow_ctl_en <= 1'b0;
			rx_buffer_size     <= `RST_RXBUF_SIZE;
			pause_timer_value  <= `RST_PAUSE_TIMER;
			wm_full            <= `RST_WM_FULL;
			wm_empty           <= `RST_WM_EMPTY;
		end else if (do_write) begin
			case (aw_addr_q)
			`OFS_CONTROL_ONE: begin
				controller_on      <= one_wr[`BIT_CTL_ON];
				receive_enable     <= one_wr[`BIT_RECEIVE_EN];
				auto_flow_ctl_en   <= one_wr[`BIT_AUTO_FC];
				manual_flow_ctl_en <= one_wr[`BIT_MANUAL_FC];
			end
			`OFS_CONTROL_TWO: begin
				rx_buffer_size <= two_wr[`RXBUF_SIZE_HI:`RXBUF_SIZE_LO];
			end
			`OFS_PAUSE_TIMER: begin
				pause_timer_value <= timer_wr[15:0];
			end
			`OFS_WATERMARK: begin
				wm_full  <= wm_wr[`WM_FULL_HI:`WM_FULL_LO];
				wm_empty <= wm_wr[`WM_EMPTY_HI:`WM_EMPTY_LO];
			end
			default: begin
			end
			endcase
		end
	end

	// (R11) Size in 16-byte units; zero is reserved and yields 0 bytes
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_buffer_bytes <= 11'h000;
		end else begin
			rx_buffer_bytes <= {rx_buffer_size, 4'h0};
		end
	end

	// Read channel, one outstanding read
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ?
				`RESP_OKAY : `RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'b00})
			// (R8) Decrement bit reads back as zero
			`OFS_CONTROL_ONE: s_axi_rdata <= {16'h0000, controller_on, 6'h00,
				receive_enable, auto_flow_ctl_en, 2'b00, manual_flow_ctl_en, 4'h0};
			`OFS_CONTROL_TWO: s_axi_rdata <= {21'h00_0000, rx_buffer_size, 4'h0};
			`OFS_PAUSE_TIMER: s_axi_rdata <= {16'h0000, pause_timer_value};
			`OFS_WATERMARK:   s_axi_rdata <= {16'h0000, wm_full, wm_empty};
			`OFS_STATUS:      s_axi_rdata <= {8'h00, rx_buffer_counter, 14'h0000,
				gen_busy, fc_prev_q};
			default:          s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Descriptor buffer counter, held at its limits
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_buffer_counter <= 8'h00;
		// (R9) Simultaneous increment and decrement cancel
		end else if (rx_buffer_inc && !buf_dec) begin
			if (rx_buffer_counter != 8'hFF) begin
				rx_buffer_counter <= rx_buffer_counter + 8'h01;
			end
		// (R8) Decrement by exactly one
		end else if (buf_dec && !rx_buffer_inc) begin
			if (rx_buffer_counter != 8'h00) begin
				rx_buffer_counter <= rx_buffer_counter - 8'h01;
			end
		end
	end

	// (R1) Watermark hysteresis, no software action
	always @(posedge aclk) begin
		if (!aresetn) begin
			auto_active_q <= 1'b0;
		end else if (!auto_flow_ctl_en) begin
			auto_active_q <= 1'b0;
		// (R2) On at full, off at empty
		end else if (rx_buffer_counter >= wm_full) begin
			auto_active_q <= 1'b1;
		end else if (rx_buffer_counter <= wm_empty) begin
			auto_active_q <= 1'b0;
		end
	end

	assign fc_on   = controller_on && (manual_flow_ctl_en || auto_active_q);
	assign fc_rise = fc_on && !fc_prev_q;
	assign fc_fall = !fc_on && fc_prev_q;

	// (R3) One flow state feeds both paths
	always @(posedge aclk) begin
		if (!aresetn) begin
			fc_prev_q   <= 1'b0;
			tx_flow_ctl <= 1'b0;
			rx_flow_ctl <= 1'b0;
		end else begin
			fc_prev_q   <= fc_on;
			tx_flow_ctl <= fc_on;
			rx_flow_ctl <= fc_on;
		end
	end

	// (R6) TX clock rate as an enable: 2.5 MHz or 25 MHz
	assign div_last = speed_100 ? DIV_LAST_100[5:0] : DIV_LAST_10[5:0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			div_q  <= 6'd0;
			tick_q <= 1'b0;
		end else if (div_q >= div_last) begin
			div_q  <= 6'd0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 6'd1;
			tick_q <= 1'b0;
		end
	end

	// (R5) Interval of 128*timer/2 TX clocks; zero timer never repeats
	assign rep_interval = {pause_timer_value, 6'h00};
	assign rep_due = fc_on && tick_q && (pause_timer_value != 16'h0000) &&
		(rep_cnt_q + 22'd1 >= rep_interval);

	always @(posedge aclk) begin
		if (!aresetn) begin
			rep_cnt_q <= 22'd0;
		end else if (!fc_on || fc_rise || rep_due) begin
			rep_cnt_q <= 22'd0;
		end else if (tick_q) begin
			rep_cnt_q <= rep_cnt_q + 22'd1;
		end
	end

	// Requests wait while a frame is still going out
	assign launch = !gen_busy && (pend_on_q || pend_zero_q);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pend_on_q   <= 1'b0;
			pend_zero_q <= 1'b0;
		end else begin
			// (R4) Rising edge queues a timed PAUSE
			if (fc_rise || rep_due) begin
				pend_on_q <= 1'b1;
			end else if (fc_fall || (launch && !pend_zero_q)) begin
				pend_on_q <= 1'b0;
			end
			// (R7) Falling edge queues a zero-time PAUSE
			if (fc_fall) begin
				pend_zero_q <= 1'b1;
			end else if (fc_rise || launch) begin
				pend_zero_q <= 1'b0;
			end
		end
	end

	pause_frame_gen u_pause (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.start        (launch),
		.timer        (pend_zero_q ? 16'h0000 : pause_timer_value),
		.station_addr (station_addr),
		.busy         (gen_busy),
		.tx_data      (pause_tx_data),
		.tx_valid     (pause_tx_valid),
		.tx_last      (pause_tx_last),
		.tx_ready     (pause_tx_ready)
	);

endmodule // eth_flow_ctl

/* rtl/flow_ctl_regs.vh */
// Register map, field positions and timing counts for the flow-control block
`ifndef FLOW_CTL_REGS_VH
`define FLOW_CTL_REGS_VH

// Byte offsets on the register bus
`define OFS_CONTROL_ONE   8'h00
`define OFS_CONTROL_TWO   8'h04
`define OFS_PAUSE_TIMER   8'h08
`define OFS_WATERMARK     8'h0C
`define OFS_STATUS        8'h10

// eth_control_one fields
`define BIT_CTL_ON        15
`define BIT_RECEIVE_EN    8
`define BIT_AUTO_FC       7
`define BIT_MANUAL_FC     4
`define BIT_BUF_DEC       0

// eth_control_two_rx_buffer_size field
`define RXBUF_SIZE_HI     10
`define RXBUF_SIZE_LO     4
`define RXBUF_UNIT_SHIFT  4

// Watermark fields
`define WM_FULL_HI        15
`define WM_FULL_LO        8
`define WM_EMPTY_HI       7
`define WM_EMPTY_LO       0

// Status fields
`define STAT_CNT_HI       23
`define STAT_CNT_LO       16
`define STAT_BIT_FC       0
`define STAT_BIT_BUSY     1

// Reset values
`define RST_CONTROL_ONE   16'h0000
`define RST_RXBUF_SIZE    7'h00
`define RST_PAUSE_TIMER   16'h0000
`define RST_WM_FULL       8'h00
`define RST_WM_EMPTY      8'h00

// Clocks in kHz; TX pacing enable derived from system clock
`define SYS_CLK_KHZ       125000
`define TX_CLK_10M_KHZ    2500
`define TX_CLK_100M_KHZ   25000
`define TX_DIV_10M        (`SYS_CLK_KHZ / `TX_CLK_10M_KHZ)
`define TX_DIV_100M       (`SYS_CLK_KHZ / `TX_CLK_100M_KHZ)

// PAUSE repeat: 128 * timer / 2 TX clocks = timer << 6
`define PAUSE_REPEAT_SHIFT 6

// MAC control frame layout, FCS excluded
`define PAUSE_FRAME_LAST  6'd59
`define MAC_CTL_TYPE      16'h8808
`define PAUSE_OPCODE      16'h0001

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* rtl/pause_frame_gen.v */
// PAUSE frame byte serialiser
`timescale 1ns/1ns
`include "flow_ctl_regs.vh"

module pause_frame_gen (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        start,
	input  wire [15:0] timer,
	input  wire [47:0] station_addr,
	output wire        busy,
	output reg  [7:0]  tx_data,
	output wire        tx_valid,
	output wire        tx_last,
	input  wire        tx_ready
);

	reg        busy_q;
	reg [5:0]  idx_q;
	reg [15:0] timer_q;

	localparam [15:0] CTL_TYPE   = `MAC_CTL_TYPE;
	localparam [15:0] CTL_OPCODE = `PAUSE_OPCODE;

	function [7:0] frame_byte;
		input [5:0]  i;
		input [15:0] t;
		input [47:0] sa;
		begin
			case (i)
			6'd0:    frame_byte = 8'h01;
			6'd1:    frame_byte = 8'h80;
			6'd2:    frame_byte = 8'hC2;
			6'd5:    frame_byte = 8'h01;
			6'd6:    frame_byte = sa[47:40];
			6'd7:    frame_byte = sa[39:32];
			6'd8:    frame_byte = sa[31:24];
			6'd9:    frame_byte = sa[23:16];
			6'd10:   frame_byte = sa[15:8];
			6'd11:   frame_byte = sa[7:0];
			6'd12:   frame_byte = CTL_TYPE[15:8];
			6'd13:   frame_byte = CTL_TYPE[7:0];
			6'd14:   frame_byte = CTL_OPCODE[15:8];
			6'd15:   frame_byte = CTL_OPCODE[7:0];
			6'd16:   frame_byte = t[15:8];
			6'd17:   frame_byte = t[7:0];
			default: frame_byte = 8'h00;
			endcase
		end
	endfunction

	assign busy     = busy_q;
	assign tx_valid = busy_q;
	assign tx_last  = busy_q && (idx_q == `PAUSE_FRAME_LAST);

	// (R13) Control frame, pause time at bytes 16-17, padded
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_q  <= 1'b0;
			idx_q   <= 6'd0;
			timer_q <= 16'h0000;
			tx_data <= 8'h00;
		end else if (!busy_q) begin
			if (start) begin
				busy_q  <= 1'b1;
				idx_q   <= 6'd0;
				timer_q <= timer;
				tx_data <= frame_byte(6'd0, timer, station_addr);
			end
		end else if (tx_ready) begin
			if (idx_q == `PAUSE_FRAME_LAST) begin
				busy_q <= 1'b0;
			end else begin
				idx_q   <= idx_q + 6'd1;
				tx_data <= frame_byte(idx_q + 6'd1, timer_q, station_addr);
			end
		end
	end

endmodule // pause_frame_gen

/* tb/eth_flow_ctl_sva.sv */
// Port-level checks for the flow-control block
`timescale 1ns/1ns
module eth_flow_ctl_sva (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        controller_on,
	input wire [6:0]  rx_buffer_size,
	input wire [10:0] rx_buffer_bytes,
	input wire        tx_flow_ctl,
	input wire        rx_flow_ctl,
	input wire [7:0]  pause_tx_data,
	input wire        pause_tx_valid,
	input wire        pause_tx_last,
	input wire        pause_tx_ready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pair; tx_flow_ctl == rx_flow_ctl; endproperty
	a_pair: assert property (p_pair) else $error("tx and rx flow differ");
	property p_bytes; 1'h1 |-> rx_buffer_bytes == {$past(rx_buffer_size), 4'h0}; endproperty
	a_bytes: assert property (p_bytes) else $error("buffer bytes wrong");
	property p_off; !controller_on [*3] |-> !tx_flow_ctl; endproperty
	a_off: assert property (p_off) else $error("flow while controller off");
	property p_start; $rose(tx_flow_ctl) |-> ##[0:8] pause_tx_valid; endproperty
	a_start: assert property (p_start) else $error("no pause after flow start");
	property p_cancel; $fell(tx_flow_ctl) |-> ##[0:8] pause_tx_valid; endproperty
	a_cancel: assert property (p_cancel) else $error("no pause after flow stop");
	property p_first; $rose(pause_tx_valid) |-> pause_tx_data == 8'h01; endproperty
	a_first: assert property (p_first) else $error("frame first byte wrong");
	property p_last; pause_tx_last |-> pause_tx_valid; endproperty
	a_last: assert property (p_last) else $error("last without valid");
	property p_hold;
		pause_tx_valid && !pause_tx_ready |=> pause_tx_valid && $stable(pause_tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled byte changed");
	property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_bblk: assert property (p_bblk) else $error("write taken during response");
endmodule // eth_flow_ctl_sva

bind eth_flow_ctl eth_flow_ctl_sva chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.controller_on(controller_on), .rx_buffer_size(rx_buffer_size),
	.rx_buffer_bytes(rx_buffer_bytes), .tx_flow_ctl(tx_flow_ctl), .rx_flow_ctl(rx_flow_ctl),
	.pause_tx_data(pause_tx_data), .pause_tx_valid(pause_tx_valid),
	.pause_tx_last(pause_tx_last), .pause_tx_ready(pause_tx_ready));

/* tb/ethernet_flow_control_rx_buffers_test.sv */
// Self-checking bench for the flow-control block
`timescale 1ns/1ns
`include "flow_ctl_regs.vh"
module ethernet_flow_control_rx_buffers_test;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, speed_100, rx_buffer_inc, controller_on, receive_enable;
	logic        tx_flow_ctl, rx_flow_ctl, pause_tx_valid, pause_tx_last, pause_tx_ready;
	logic        stall;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, pause_tx_data;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
	logic [6:0]  rx_buffer_size;
	logic [10:0] rx_buffer_bytes;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [47:0] station_addr = 48'h0200_1122_3344;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;

	eth_flow_ctl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .speed_100, .rx_buffer_inc, .station_addr, .controller_on,
		.receive_enable, .rx_buffer_size, .rx_buffer_bytes, .tx_flow_ctl, .rx_flow_ctl,
		.pause_tx_data, .pause_tx_valid, .pause_tx_last, .pause_tx_ready);
	pause_sink sink (.aclk, .stall, .data(pause_tx_data), .valid(pause_tx_valid),
		.last(pause_tx_last), .ready(pause_tx_ready));

	initial aclk = 1'h0;
	always #4 aclk = ~aclk;

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Ceiling well above the longest run
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			end_sim;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic inc);
		logic aw_p;
		logic w_p;
		aw_p = 1'h1;
		w_p = 1'h1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// Each half released at its own handshake
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (aw_p && s_axi_awready) begin
				aw_p = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w_p && s_axi_wready) begin
				w_p = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		// Increment lands on the update edge
		rx_buffer_inc <= inc;
		@(posedge aclk);
		rx_buffer_inc <= 1'h0;
		@(posedge aclk iff s_axi_bvalid);
		bresp_q = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		@(posedge aclk iff s_axi_arready);
		s_axi_arvalid <= 1'h0;
		@(posedge aclk iff s_axi_rvalid);
		d = s_axi_rdata;
		rresp_q = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic pulse;
		@(posedge aclk);
		rx_buffer_inc <= 1'h1;
		@(posedge aclk);
		rx_buffer_inc <= 1'h0;
	endtask

	task automatic wait_frames(input int n, input int lim);
		int k;
		k = 0;
		while (sink.frames < n && k < lim) begin
			@(posedge aclk);
			k++;
		end
		chk(sink.frames, n);
	endtask

	task automatic check_frame(input logic [15:0] tv);
		logic [143:0] h;
		h = {48'h0180_c200_0001, station_addr, 32'h8808_0001, tv};
		chk(sink.len_q, 60);
		for (int i = 0; i < 60; i++)
			chk(sink.frame_q[i], i < 18 ? h[143 - 8 * i -: 8] : 8'h00);
	endtask

	task automatic t_regs;
		logic [31:0] d;
		for (int i = 0; i < 5; i++) begin
			rd(8'(i * 4), d);
			chk(d, 32'h0000_0000);
		end
		rd(8'h14, d);
		chk(rresp_q, `RESP_SLVERR);
		wr(8'h14, 32'hffff_ffff, 1'h0);
		chk(bresp_q, `RESP_SLVERR);
		// Partial strobe touches one byte only
		s_axi_wstrb <= 4'h2;
		wr(`OFS_WATERMARK, 32'h0000_5566, 1'h0);
		s_axi_wstrb <= 4'hf;
		chk(bresp_q, `RESP_OKAY);
		rd(`OFS_WATERMARK, d);
		chk(d, 32'h0000_5500);
		$display("register reset test done");
	endtask

	task automatic t_size;
		logic [31:0] d;
		logic [6:0]  v [3] = '{7'h7f, 7'h01, 7'h60};
		foreach (v[i]) begin
			wr(`OFS_CONTROL_TWO, {21'h0, v[i], 4'h0}, 1'h0);
			rd(`OFS_CONTROL_TWO, d);
			chk(d, {21'h0, v[i], 4'h0});
			chk({21'h0, rx_buffer_bytes}, {21'h0, v[i] * 11'h010});
		end
		$display("buffer size test done");
	endtask

	task automatic t_auto;
		int f;
		f = sink.frames;
		wr(`OFS_PAUSE_TIMER, 32'h0000_0000, 1'h0);
		wr(`OFS_WATERMARK, 32'h0000_0301, 1'h0);
		wr(`OFS_CONTROL_ONE, 32'h0000_8080, 1'h0);
		repeat (2) pulse;
		repeat (4) @(posedge aclk);
		chk(tx_flow_ctl, 1'h0);
		pulse;
		repeat (4) @(posedge aclk);
		chk(tx_flow_ctl, 1'h1);
		chk(rx_flow_ctl, 1'h1);
		wr(`OFS_CONTROL_ONE, 32'h0000_8081, 1'h0);
		repeat (4) @(posedge aclk);
		chk(tx_flow_ctl, 1'h1);
		wr(`OFS_CONTROL_ONE, 32'h0000_8081, 1'h0);
		repeat (4) @(posedge aclk);
		chk(tx_flow_ctl, 1'h0);
		chk(rx_flow_ctl, 1'h0);
		// Start frame, then the queued cancel frame
		wait_frames(f + 2, 400);
		check_frame(16'h0000);
		$display("auto flow test done");
	endtask

	task automatic t_dec;
		logic [31:0] d;
		wr(`OFS_CONTROL_ONE, 32'h0000_8000, 1'h0);
		repeat (2) pulse;
		rd(`OFS_STATUS, d);
		chk(d[23:16], 8'h03);
		wr(`OFS_CONTROL_ONE, 32'h0000_8001, 1'h1);
		rd(`OFS_STATUS, d);
		chk(d[23:16], 8'h03);
		wr(`OFS_CONTROL_ONE, 32'h0000_8001, 1'h0);
		rd(`OFS_STATUS, d);
		chk(d[23:16], 8'h02);
		rd(`OFS_CONTROL_ONE, d);
		chk(d, 32'h0000_8000);
		wr(`OFS_CONTROL_ONE, 32'h0000_8000, 1'h0);
		rd(`OFS_STATUS, d);
		chk(d[23:16], 8'h02);
		wr(`OFS_CONTROL_ONE, 32'h0000_8100, 1'h0);
		rd(`OFS_CONTROL_ONE, d);
		chk(d, 32'h0000_8100);
		chk({receive_enable, controller_on}, 2'h3);
		$display("decrement test done");
	endtask

	task automatic t_manual(input logic spd, input logic [15:0] tv);
		int per;
		int f;
		per = tv * 64 * (spd ? 5 : 50);
		speed_100 <= spd;
		stall <= spd;
		wr(`OFS_PAUSE_TIMER, {16'h0, tv}, 1'h0);
		f = sink.frames;
		wr(`OFS_CONTROL_ONE, 32'h0000_8010, 1'h0);
		wait_frames(f + 1, 300);
		check_frame(tv);
		chk(tx_flow_ctl & rx_flow_ctl, 1'h1);
		repeat (per * 7 / 10) @(posedge aclk);
		chk(sink.frames, f + 1);
		wait_frames(f + 2, per);
		check_frame(tv);
		wr(`OFS_CONTROL_ONE, 32'h0000_8000, 1'h0);
		wait_frames(f + 3, 300);
		check_frame(16'h0000);
		chk(tx_flow_ctl, 1'h0);
		$display("manual flow test done");
	endtask

	initial begin
		aresetn = 1'h0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'h0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		speed_100 = 1'h1;
		rx_buffer_inc = 1'h0;
		stall = 1'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs;
		t_size;
		t_auto;
		t_dec;
		t_manual(1'h1, 16'h0002);
		t_manual(1'h0, 16'h0001);
		end_sim;
	end
endmodule // ethernet_flow_control_rx_buffers_test

/* tb/pause_sink.sv */
// Link-side sink taking PAUSE frame bytes
`timescale 1ns/1ns
module pause_sink (
	input  wire       aclk,
	input  wire       stall,
	input  wire [7:0] data,
	input  wire       valid,
	input  wire       last,
	output logic      ready
);
	logic [7:0] frame_q [0:59];
	int         idx = 0;
	int         frames = 0;
	int         len_q = 0;
	always @(posedge aclk) begin
		if (valid && ready) begin
			frame_q[idx] <= data;
			idx <= last ? 0 : idx + 1;
			if (last) begin
				frames <= frames + 1;
				len_q <= idx + 1;
			end
		end
		// Stalling halves the byte rate
		ready <= stall ? ~ready : 1'h1;
	end
endmodule // pause_sink
